//--- ffei_defines.svh
`ifndef FFEI_DEFINES_SVH
`define FFEI_DEFINES_SVH

// ==========================================================
// Machine state bit positions (bit 0 is the lsb)
`define FFEI_MSR_AP 25
`define FFEI_MSR_APE 19
`define FFEI_MSR_WE 18
`define FFEI_MSR_CE 17
`define FFEI_MSR_EE 15
`define FFEI_MSR_PR 14
`define FFEI_MSR_FP 13
`define FFEI_MSR_ME 12
`define FFEI_MSR_FE0 11
`define FFEI_MSR_DWE 10
`define FFEI_MSR_DE 9
`define FFEI_MSR_FE1 8
`define FFEI_MSR_IR 5
`define FFEI_MSR_DR 4
// Bits cleared on entry: AP APE WE EE PR FP FE0 DWE FE1 IR DR
`define FFEI_MSR_ENTRY_CLR 32'h020ced30

// ==========================================================
// Syndrome bit positions
`define FFEI_ESR_MCI 31
`define FFEI_ESR_DIZ 23

// ==========================================================
// Vector low half-words
`define FFEI_VEC_ISI 16'h0400
`define FFEI_VEC_EXT 16'h0500
`define FFEI_VEC_PIT 16'h1000
`define FFEI_VEC_FIT 16'h1010

// ==========================================================
// Zone field codes
`define FFEI_ZONE_NONE 2'h0
`define FFEI_ZONE_SUP 2'h2
`define FFEI_ZONE_ALL 2'h3

// ==========================================================
// Widths and reset values
`define FFEI_EXT_SRC_W 4
`define FFEI_RST_WORD 32'h0000_0000

`endif

//--- ffei_pkg.sv
`default_nettype none
package ffei_pkg;
  typedef enum logic [2:0] {
    FFEI_CAUSE_NONE = 3'b000,
    FFEI_CAUSE_ISI = 3'b001,
    FFEI_CAUSE_EXT = 3'b010,
    FFEI_CAUSE_PIT = 3'b011,
    FFEI_CAUSE_FIT = 3'b100,
    FFEI_CAUSE_RFI = 3'b101
  } ffei_cause_t;
endpackage : ffei_pkg
`default_nettype wire

//--- ffei_fetch_check.sv
`include "ffei_defines.svh"
`default_nettype none
module ffei_fetch_check
(
  input wire logic translate_on_i, // Fetch translation active
  input wire logic user_i, // User state
  input wire logic [1:0] zone_i, // Zone field of the page
  input wire logic run_permit_i, // Page execute permission
  input wire logic no_prefetch_i, // Guarded region
  output logic fault_o, // Fetch not permitted
  output logic zone_fault_o // Fault is a user zone 00 fault
);
  wire zone_deny;
  wire run_deny_user;
  wire run_deny_sup;
  wire guard_deny;

  assign zone_deny = user_i && zone_i == `FFEI_ZONE_NONE;
  assign run_deny_user = user_i && !run_permit_i
    && zone_i != `FFEI_ZONE_ALL;
  assign run_deny_sup = !user_i && !run_permit_i
    && zone_i != `FFEI_ZONE_ALL && zone_i != `FFEI_ZONE_SUP;
  assign guard_deny = no_prefetch_i;
  assign fault_o = translate_on_i
    && (zone_deny || run_deny_user || run_deny_sup || guard_deny);
  assign zone_fault_o = translate_on_i && zone_deny;
endmodule : ffei_fetch_check
`default_nettype wire

//--- ffei_entry.sv
`include "ffei_defines.svh"
`default_nettype none
module ffei_entry
(
  input wire logic clk_sys_i, // Core clock
  input wire logic arst_n_i, // Async reset, active low
  input wire logic exec_valid_i, // Instruction about to execute
  input wire logic [31:0] exec_pc_i, // Its effective address
  input wire logic [31:0] next_seq_pc_i, // Next sequential address
  input wire logic [1:0] fetch_zone_i, // Zone field of its page
  input wire logic fetch_run_permit_i, // Page run permission
  input wire logic fetch_no_prefetch_i, // Page is guarded
  input wire logic return_i, // Return from handler executes
  input wire logic [`FFEI_EXT_SRC_W-1:0] ext_irq_i, // Level sources
  input wire logic interval_timer_i, // Interval timer request
  input wire logic fixed_period_timer_i, // Fixed period request
  input wire logic msr_wr_i, // Software writes state
  input wire logic [31:0] msr_wdata_i, // State write data
  input wire logic vector_prefix_reg_wr_i, // Software writes prefix
  input wire logic [31:0] vector_prefix_reg_wdata_i, // Prefix write data
  input wire logic esr_wr_i, // Software writes syndrome
  input wire logic [31:0] esr_wdata_i, // Syndrome write data
  output ffei_pkg::ffei_cause_t cause_o, // Event taken now
  output logic ext_req_o, // Gated external request
  output logic redirect_o, // Fetch redirect pulse
  output logic [31:0] redirect_pc_o, // New program counter
  output logic [31:0] machine_state_o, // Machine state
  output logic [31:0] saved_pc_o, // Saved address
  output logic [31:0] saved_msr_o, // Saved state
  output logic [31:0] syndrome_o, // Exception syndrome
  output logic [31:0] vector_prefix_o // Vector prefix
);
  import ffei_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] vec_addr(input logic [31:0] pfx,
    input logic [15:0] low);
    vec_addr = {pfx[31:16], low};
  endfunction : vec_addr

  function automatic logic [31:0] entry_state(input logic [31:0] st);
    entry_state = st & ~`FFEI_MSR_ENTRY_CLR;
  endfunction : entry_state

  // ==========================================================
  // Registers
  logic [31:0] machine_state_reg;
  logic [31:0] machine_state_next;
  logic [31:0] saved_pc_reg;
  logic [31:0] saved_pc_next;
  logic [31:0] saved_msr_reg;
  logic [31:0] saved_msr_next;
  logic [31:0] exception_syndrome_reg;
  logic [31:0] exception_syndrome_next;
  logic [31:0] vector_prefix_reg;
  logic [31:0] vector_prefix_next;
  logic redirect_reg;
  logic [31:0] redirect_pc_reg;
  logic [31:0] redirect_pc_next;

  // ==========================================================
  // Fetch permission check
  wire fetch_fault;
  wire zone_fault;
  wire ext_int_enable;
  wire user_state_bit;
  wire fetch_translate_on;

  assign ext_int_enable = machine_state_reg[`FFEI_MSR_EE];
  assign user_state_bit = machine_state_reg[`FFEI_MSR_PR];
  assign fetch_translate_on = machine_state_reg[`FFEI_MSR_IR];

  ffei_fetch_check u_check
  (
    .translate_on_i(fetch_translate_on),
    .user_i(user_state_bit),
    .zone_i(fetch_zone_i),
    .run_permit_i(fetch_run_permit_i),
    .no_prefetch_i(fetch_no_prefetch_i),
    .fault_o(fetch_fault),
    .zone_fault_o(zone_fault)
  );

  // ==========================================================
  // Request merge and priority
  wire ext_any;
  wire isi_take;
  wire ext_take;
  wire pit_take;
  wire fit_take;
  wire ret_take;
  ffei_cause_t cause;

  assign ext_any = |ext_irq_i;
  assign ext_req_o = ext_any && ext_int_enable;
  // Fault only when the refused instruction reaches execute
  assign isi_take = exec_valid_i && fetch_fault;
  assign ext_take = exec_valid_i && !isi_take && ext_req_o;
  assign pit_take = exec_valid_i && !isi_take && !ext_req_o
    && ext_int_enable && interval_timer_i;
  assign fit_take = exec_valid_i && !isi_take && !ext_req_o
    && !interval_timer_i && ext_int_enable
    && fixed_period_timer_i;
  assign ret_take = exec_valid_i && return_i && !isi_take
    && !ext_take && !pit_take && !fit_take;
  assign cause = isi_take ? FFEI_CAUSE_ISI :
                 ext_take ? FFEI_CAUSE_EXT :
                 pit_take ? FFEI_CAUSE_PIT :
                 fit_take ? FFEI_CAUSE_FIT :
                 ret_take ? FFEI_CAUSE_RFI : FFEI_CAUSE_NONE;
  assign cause_o = cause;

  // ==========================================================
  // Next-state selection
  always_comb
  begin
    machine_state_next = msr_wr_i ? msr_wdata_i : machine_state_reg;
    saved_pc_next = saved_pc_reg;
    saved_msr_next = saved_msr_reg;
    exception_syndrome_next = esr_wr_i ? esr_wdata_i
      : exception_syndrome_reg;
    vector_prefix_next = vector_prefix_reg_wr_i ? vector_prefix_reg_wdata_i : vector_prefix_reg;
    redirect_pc_next = redirect_pc_reg;
    case (cause)
      FFEI_CAUSE_ISI:
      begin
        saved_pc_next = exec_pc_i;
        saved_msr_next = machine_state_reg;
        machine_state_next = entry_state(machine_state_reg);
        exception_syndrome_next = 32'h0000_0000;
        exception_syndrome_next[`FFEI_ESR_MCI] =
          exception_syndrome_reg[`FFEI_ESR_MCI];
        exception_syndrome_next[`FFEI_ESR_DIZ] = zone_fault;
        redirect_pc_next = vec_addr(vector_prefix_reg,
          `FFEI_VEC_ISI);
      end
      FFEI_CAUSE_EXT:
      begin
        saved_pc_next = next_seq_pc_i;
        saved_msr_next = machine_state_reg;
        machine_state_next = entry_state(machine_state_reg);
        redirect_pc_next = vec_addr(vector_prefix_reg,
          `FFEI_VEC_EXT);
      end
      FFEI_CAUSE_PIT:
      begin
        saved_pc_next = next_seq_pc_i;
        saved_msr_next = machine_state_reg;
        machine_state_next = entry_state(machine_state_reg);
        redirect_pc_next = vec_addr(vector_prefix_reg,
          `FFEI_VEC_PIT);
      end
      FFEI_CAUSE_FIT:
      begin
        saved_pc_next = next_seq_pc_i;
        saved_msr_next = machine_state_reg;
        machine_state_next = entry_state(machine_state_reg);
        redirect_pc_next = vec_addr(vector_prefix_reg,
          `FFEI_VEC_FIT);
      end
      FFEI_CAUSE_RFI:
      begin
        machine_state_next = saved_msr_reg;
        redirect_pc_next = saved_pc_reg;
      end
      default:
      begin
        redirect_pc_next = redirect_pc_reg;
      end
    endcase
  end

  // ==========================================================
  // State
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      machine_state_reg <= `FFEI_RST_WORD;
      saved_pc_reg <= `FFEI_RST_WORD;
      saved_msr_reg <= `FFEI_RST_WORD;
      exception_syndrome_reg <= `FFEI_RST_WORD;
      vector_prefix_reg <= `FFEI_RST_WORD;
      redirect_reg <= 1'b0;
      redirect_pc_reg <= `FFEI_RST_WORD;
    end
    else
    begin
      machine_state_reg <= machine_state_next;
      saved_pc_reg <= saved_pc_next;
      saved_msr_reg <= saved_msr_next;
      exception_syndrome_reg <= exception_syndrome_next;
      vector_prefix_reg <= vector_prefix_next;
      redirect_reg <= cause != FFEI_CAUSE_NONE;
      redirect_pc_reg <= redirect_pc_next;
    end
  end

  assign redirect_o = redirect_reg;
  assign redirect_pc_o = redirect_pc_reg;
  assign machine_state_o = machine_state_reg;
  assign saved_pc_o = saved_pc_reg;
  assign saved_msr_o = saved_msr_reg;
  assign syndrome_o = exception_syndrome_reg;
  assign vector_prefix_o = vector_prefix_reg;

  // ==========================================================
  // Checks
  fault_at_exec_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    (cause == FFEI_CAUSE_ISI) |-> exec_valid_i && fetch_translate_on)
    else $error("fetch fault without execute or translation");
  zone_user_fault_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    exec_valid_i && fetch_translate_on && user_state_bit
    && fetch_zone_i == `FFEI_ZONE_NONE |-> cause == FFEI_CAUSE_ISI)
    else $error("user zone 00 fetch not faulted");
  user_run_deny_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    exec_valid_i && fetch_translate_on && user_state_bit
    && !fetch_run_permit_i && fetch_zone_i != `FFEI_ZONE_ALL
    |-> cause == FFEI_CAUSE_ISI)
    else $error("user no-run fetch not faulted");
  sup_run_deny_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    exec_valid_i && fetch_translate_on && !user_state_bit
    && !fetch_no_prefetch_i && fetch_zone_i[1]
    |-> cause != FFEI_CAUSE_ISI)
    else $error("supervisor fault in zone 10/11");
  guarded_fetch_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    exec_valid_i && fetch_translate_on && fetch_no_prefetch_i
    |-> cause == FFEI_CAUSE_ISI)
    else $error("guarded fetch not faulted");
  isi_save_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    (cause == FFEI_CAUSE_ISI) |=> saved_pc_o == $past(exec_pc_i)
    && saved_msr_o == $past(machine_state_reg))
    else $error("fault entry saved wrong values");
  isi_syndrome_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    (cause == FFEI_CAUSE_ISI) |=> syndrome_o[`FFEI_ESR_DIZ]
    == $past(user_state_bit && fetch_zone_i == `FFEI_ZONE_NONE)
    && syndrome_o[`FFEI_ESR_MCI] == $past(syndrome_o[`FFEI_ESR_MCI])
    && (syndrome_o & 32'h7f7f_ffff) == 32'h0000_0000)
    else $error("fault syndrome wrong");
  isi_vector_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    (cause == FFEI_CAUSE_ISI) |=> redirect_o
    && redirect_pc_o == {$past(vector_prefix_reg[31:16]), 16'h0400})
    else $error("fault vector wrong");
  entry_state_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    (cause == FFEI_CAUSE_ISI || cause == FFEI_CAUSE_EXT)
    |=> (machine_state_o & 32'h020ced30) == 32'h0000_0000
    && (machine_state_o & 32'h0002_1200)
    == ($past(machine_state_reg) & 32'h0002_1200))
    else $error("entry state bits wrong");
  ext_merge_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    ext_req_o == ((ext_irq_i != '0) && ext_int_enable))
    else $error("merged request wrong");
  ext_masked_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    !ext_int_enable |-> cause != FFEI_CAUSE_EXT
    && cause != FFEI_CAUSE_PIT && cause != FFEI_CAUSE_FIT)
    else $error("masked request taken");
  timer_vector_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    (cause == FFEI_CAUSE_PIT || cause == FFEI_CAUSE_FIT)
    |=> redirect_pc_o[15:0] != 16'h0500)
    else $error("timer used external vector");
  ext_save_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    (cause == FFEI_CAUSE_EXT) |=> saved_pc_o == $past(next_seq_pc_i)
    && saved_msr_o == $past(machine_state_reg))
    else $error("external entry saved wrong values");
  ext_vector_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    (cause == FFEI_CAUSE_EXT) |=> redirect_o
    && redirect_pc_o == {$past(vector_prefix_reg[31:16]), 16'h0500})
    else $error("external vector wrong");
  return_restore_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    (cause == FFEI_CAUSE_RFI) |=> redirect_o
    && redirect_pc_o == $past(saved_pc_reg)
    && machine_state_o == $past(saved_msr_reg))
    else $error("return restore wrong");
endmodule : ffei_entry
`default_nettype wire

//--- ffei_src_model.sv
`default_nettype none
module ffei_src_model
(
  input wire logic clk_sys_i, // Core clock
  input wire logic arst_n_i, // Async reset, active low
  input wire logic [3:0] raise_i, // Source starts requesting
  input wire logic [3:0] serviced_i, // Handler cleared the source
  output logic [3:0] irq_o // Level requests
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] irq_reg;
  logic [3:0] irq_next;
  // ========================================
  // Level held until the handler clears it
  assign irq_next = (irq_reg | raise_i) & ~serviced_i;
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      irq_reg <= 4'h0;
    else
      irq_reg <= irq_next;
  end
  assign irq_o = irq_reg;
endmodule : ffei_src_model
`default_nettype wire

//--- tb_top.sv
`include "ffei_defines.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ffei_pkg::*;
  localparam logic [31:0] EE = 32'h1 << `FFEI_MSR_EE;
  localparam logic [31:0] IR = 32'h1 << `FFEI_MSR_IR;
  localparam logic [31:0] PR = 32'h1 << `FFEI_MSR_PR;
  logic clk, arst_n, exec_valid, perm, grd, ret, interval_timer, fixed_period_timer;
  logic msr_wr, vector_prefix_reg_wr, esr_wr, ext_req, redir;
  logic [1:0] zone;
  logic [3:0] raise, serv, ext_irq;
  logic [31:0] exec_pc, nsq, msr_wd, vector_prefix_reg_wd, esr_wd, redir_pc;
  logic [31:0] state, sv_pc, sv_msr, synd, prefix;
  ffei_cause_t cause;
  int miscompares, tests_run, cycles;
  ffei_src_model src (.clk_sys_i(clk), .arst_n_i(arst_n),
    .raise_i(raise), .serviced_i(serv), .irq_o(ext_irq));
  ffei_entry uut (.clk_sys_i(clk), .arst_n_i(arst_n),
    .exec_valid_i(exec_valid), .exec_pc_i(exec_pc), .next_seq_pc_i(nsq),
    .fetch_zone_i(zone), .fetch_run_permit_i(perm),
    .fetch_no_prefetch_i(grd), .return_i(ret), .ext_irq_i(ext_irq),
    .interval_timer_i(interval_timer), .fixed_period_timer_i(fixed_period_timer),
    .msr_wr_i(msr_wr), .msr_wdata_i(msr_wd), .vector_prefix_reg_wr_i(vector_prefix_reg_wr),
    .vector_prefix_reg_wdata_i(vector_prefix_reg_wd), .esr_wr_i(esr_wr), .esr_wdata_i(esr_wd),
    .cause_o(cause), .ext_req_o(ext_req), .redirect_o(redir),
    .redirect_pc_o(redir_pc), .machine_state_o(state),
    .saved_pc_o(sv_pc), .saved_msr_o(sv_msr), .syndrome_o(synd),
    .vector_prefix_o(prefix));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ========================================
  // Shared tasks
  task automatic check(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("Counts: %0d compares, %0d mismatches", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  // Software write: 0 state, 1 prefix, 2 syndrome
  task automatic wr(input int which, input logic [31:0] d);
    msr_wr = (which == 0);
    vector_prefix_reg_wr = (which == 1);
    esr_wr = (which == 2);
    msr_wd = d;
    vector_prefix_reg_wd = d;
    esr_wd = d;
    @(negedge clk);
    msr_wr = 1'b0;
    vector_prefix_reg_wr = 1'b0;
    esr_wr = 1'b0;
    @(negedge clk);
  endtask : wr
  task automatic pulse_src(input logic [3:0] r, input logic [3:0] s);
    raise = r;
    serv = s;
    @(negedge clk);
    raise = 4'h0;
    serv = 4'h0;
    @(negedge clk);
  endtask : pulse_src
  // One instruction at execute; judges entry side effects
  task automatic ex(input logic [31:0] pc, input logic [1:0] z,
    input logic p, input logic g, input logic r, input ffei_cause_t ec,
    input logic [31:0] epc);
    logic [31:0] old;
    old = state;
    exec_valid = 1'b1;
    exec_pc = pc;
    nsq = pc + 32'h4;
    zone = z;
    perm = p;
    grd = g;
    ret = r;
    #1;
    check("cause", {29'h0, cause}, {29'h0, ec});
    @(negedge clk);
    exec_valid = 1'b0;
    grd = 1'b0;
    ret = 1'b0;
    check("redirect", 32'(redir), 32'(ec != FFEI_CAUSE_NONE));
    if (ec == FFEI_CAUSE_NONE)
      check("state kept", state, old);
    else
    begin
      check("new pc", redir_pc, epc);
      if (ec != FFEI_CAUSE_RFI)
      begin
        check("state", state, old & ~`FFEI_MSR_ENTRY_CLR);
        check("saved msr", sv_msr, old);
        check("saved pc", sv_pc, ec == FFEI_CAUSE_ISI ? pc : nsq);
      end
    end
    @(negedge clk);
    check("pulse ends", {31'h0, redir}, 32'h0);
  endtask : ex
  // ========================================
  // Scenarios
  task automatic t_fetch();
    logic [31:0] st, sy;
    logic u, zf, flt;
    for (int i = 0; i < 32; i++)
    begin
      u = i[4];
      zf = u && i[3:2] == `FFEI_ZONE_NONE;
      flt = zf || i[0] || (!i[1] && i[3:2] != `FFEI_ZONE_ALL
        && (u || i[3:2] != `FFEI_ZONE_SUP));
      st = u ? 32'hffff_ffff : ~PR;
      wr(0, st);
      // Supervisor passes start with the machine check flag clear
      sy = u ? 32'hffff_ffff : 32'h7fff_ffff;
      wr(2, sy);
      if (flt)
      begin
        sy = sy & (32'h1 << `FFEI_ESR_MCI);
        sy[`FFEI_ESR_DIZ] = zf;
      end
      ex(32'h0000_3000 + 32'(i) * 4, i[3:2], i[1], i[0], 1'b0,
        flt ? FFEI_CAUSE_ISI : FFEI_CAUSE_NONE, 32'habcd_0400);
      check("syndrome", synd, sy);
    end
    wr(0, ~IR);
    ex(32'h4000, 2'h0, 1'b0, 1'b1, 1'b0, FFEI_CAUSE_NONE, 32'h0);
    grd = 1'b1;
    wr(0, 32'hffff_ffff);
    check("no fault idle", {31'h0, redir}, 32'h0);
    grd = 1'b0;
    $display("done: fetch fault");
  endtask : t_fetch
  task automatic t_ext();
    for (int k = 0; k < 4; k++)
    begin
      wr(0, PR);
      pulse_src(4'h1 << k, 4'h0);
      check("masked req", {31'h0, ext_req}, 32'h0);
      ex(32'h100, 2'h3, 1'b1, 1'b0, 1'b0, FFEI_CAUSE_NONE, 32'h0);
      wr(0, EE | PR | (32'h1 << `FFEI_MSR_CE));
      check("merged req", {31'h0, ext_req}, 32'h1);
      ex(32'h200, 2'h3, 1'b1, 1'b0, 1'b0, FFEI_CAUSE_EXT,
        32'habcd_0500);
      check("req gated", {31'h0, ext_req}, 32'h0);
      pulse_src(4'h0, 4'hf);
    end
    pulse_src(4'h4, 4'h0);
    wr(0, EE | IR);
    ex(32'h300, 2'h3, 1'b1, 1'b1, 1'b0, FFEI_CAUSE_ISI,
      32'habcd_0400);
    pulse_src(4'h0, 4'hf);
    $display("done: external");
  endtask : t_ext
  task automatic t_timer();
    for (int t = 0; t < 2; t++)
    begin
      wr(0, 32'h0);
      interval_timer = (t == 0);
      fixed_period_timer = (t == 1);
      ex(32'h400, 2'h3, 1'b1, 1'b0, 1'b0, FFEI_CAUSE_NONE, 32'h0);
      wr(0, EE);
      ex(32'h500, 2'h3, 1'b1, 1'b0, 1'b0, t == 0 ? FFEI_CAUSE_PIT :
        FFEI_CAUSE_FIT, t == 0 ? 32'habcd_1000 : 32'habcd_1010);
      interval_timer = 1'b0;
      fixed_period_timer = 1'b0;
    end
    $display("done: timers");
  endtask : t_timer
  task automatic t_return();
    wr(0, EE | PR);
    pulse_src(4'h2, 4'h0);
    ex(32'h600, 2'h3, 1'b1, 1'b0, 1'b0, FFEI_CAUSE_EXT,
      32'habcd_0500);
    pulse_src(4'h0, 4'hf);
    ex(32'h700, 2'h3, 1'b1, 1'b0, 1'b1, FFEI_CAUSE_RFI, 32'h604);
    check("restored msr", state, EE | PR);
    $display("done: return");
  endtask : t_return
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  initial
  begin
    {arst_n, exec_valid, perm, grd, ret, interval_timer, fixed_period_timer} = 7'h0;
    {msr_wr, vector_prefix_reg_wr, esr_wr, zone, raise, serv} = 13'h0;
    {exec_pc, nsq, msr_wd, vector_prefix_reg_wd, esr_wd} = 160'h0;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    check("reset state", state, 32'h0);
    check("reset saved", sv_pc | sv_msr | synd | prefix, 32'h0);
    wr(1, 32'habcd_1234);
    check("prefix", prefix, 32'habcd_1234);
    t_fetch();
    t_ext();
    t_timer();
    t_return();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
